// ==== jmpc_port.sv ====
// Master port 2 control: arbitration, pin directions, configuration entry, conflict flag.
`timescale 1ns/1ps

// Function
// (R1) As master the port's clock, mode-select, data-in and test reset are inputs and data-out an output, reversed in slave mode.
// (R2) As master, a low test reset puts the device into configuration mode with access to the switch TAP controller.
// (R3) Toggling the test reset while the port is not master has no effect at all.
// (R4) The master's test reset never drives the test resets of secondary ports.
// (R5) A low global reset clears all global logic at once, without a clock; it is held high in normal use.
// (R6) The conflict indicator goes low when two or more of the three master requests are low together.
// (R7) The outside party drives the periphery chain clock, mode-select and data inputs to defined levels.
// (R8) The outside party holds the periphery chain test reset low in normal operation.
// (R9) Port 2 is master only when external and master 1 requests are inactive and port 2 requests.
// (R10) The port 2 grant output is low for as long as port 2 is master.
module jmpc_port
    import jmpc_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    input  wire logic global_reset_n_i,
    input  wire logic master2_test_clock_i,
    input  wire logic external_request_n_i,
    input  wire logic master1_request_n_i,
    input  wire logic master2_request_n_i,
    input  wire logic master2_test_reset_n_i,
    output logic      master2_test_reset_n_o,
    output logic      master2_test_reset_n_oe_o,
    input  wire logic master2_mode_select_i,
    output logic      master2_mode_select_o,
    output logic      master2_mode_select_oe_o,
    input  wire logic master2_data_in_i,
    output logic      master2_data_in_o,
    output logic      master2_data_in_oe_o,
    output logic      master2_test_clock_o,
    output logic      master2_test_clock_oe_o,
    input  wire logic master2_data_out_i,
    output logic      master2_data_out_o,
    output logic      master2_data_out_oe_o,
    input  wire logic switch_data_i,
    input  wire logic slave_clock_i,
    input  wire logic slave_mode_select_i,
    input  wire logic slave_data_i,
    input  wire logic slave_test_reset_n_i,
    output logic      switch_data_o,
    output logic      config_mode_o,
    output logic      master2_grant_n_o,
    output logic      master_conflict_n_o,
    input  wire logic periph_chain_clock_i,
    input  wire logic periph_chain_mode_select_i,
    input  wire logic periph_chain_data_in_i,
    input  wire logic periph_chain_reset_n_i,
    output logic      periph_chain_data_out_o
);

    typedef struct packed {
        logic [SYNC_STAGES-1:0] req_ext_s;
        logic [SYNC_STAGES-1:0] req_m1_s;
        logic [SYNC_STAGES-1:0] req_m2_s;
        logic [SYNC_STAGES-1:0] trst_s;
        jmpc_port_e             state;
        logic                   grant_n;
        logic                   conflict_n;
        logic                   config_mode;
    } jmpc_core_s;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] master_s;
        logic                   data_out;
    } jmpc_link_s;

    jmpc_core_s core_r;
    jmpc_core_s core_nxt;
    jmpc_link_s link_r;
    jmpc_link_s link_nxt;
    logic       is_master;
    logic       sys_rst_n;

    assign sys_rst_n = rst_b_i & global_reset_n_i;
    assign is_master = (core_r.state != JMPC_ST_SLAVE);

    always_comb begin
        logic [1:0] cnt;
        cnt      = 2'h0;
        core_nxt = core_r;
        core_nxt.req_ext_s = {core_r.req_ext_s[0], external_request_n_i};
        core_nxt.req_m1_s  = {core_r.req_m1_s[0], master1_request_n_i};
        core_nxt.req_m2_s  = {core_r.req_m2_s[0], master2_request_n_i};
        // The pipeline is held inactive in slave mode, so a low driven out there cannot leak in. [R3]
        core_nxt.trst_s    = is_master ? {core_r.trst_s[0], master2_test_reset_n_i} : 2'h3;
        cnt = {1'b0, ~core_r.req_ext_s[1]} + {1'b0, ~core_r.req_m1_s[1]}
            + {1'b0, ~core_r.req_m2_s[1]};
        core_nxt.conflict_n = ~(cnt >= 2'h2); // [R6]
        case (core_r.state)
            JMPC_ST_SLAVE: begin
                if (core_r.req_ext_s[1] && core_r.req_m1_s[1] && !core_r.req_m2_s[1]) begin
                    core_nxt.state = JMPC_ST_MASTER; // [R9]
                end
            end
            JMPC_ST_MASTER, JMPC_ST_CONFIG: begin
                if (!(core_r.req_ext_s[1] && core_r.req_m1_s[1] && !core_r.req_m2_s[1])) begin
                    core_nxt.state = JMPC_ST_SLAVE; // [R9]
                end else if (!core_r.trst_s[1]) begin
                    core_nxt.state = JMPC_ST_CONFIG; // [R2]
                end else begin
                    core_nxt.state = JMPC_ST_MASTER;
                end
            end
            default: core_nxt.state = JMPC_ST_SLAVE;
        endcase
        // Test reset is only sampled inside the master states, so slave toggles vanish. [R3]
        core_nxt.grant_n     = (core_nxt.state == JMPC_ST_SLAVE); // [R10]
        core_nxt.config_mode = (core_nxt.state == JMPC_ST_CONFIG); // [R2]
    end

    // Global reset is asynchronous; the board reset is synchronous. [R5]
    always_ff @(posedge ref_clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            core_r <= '{default: 1'b1, state: JMPC_ST_SLAVE, config_mode: CONFIG_RST};
        end else if (!rst_b_i) begin
            core_r <= '{default: 1'b1, state: JMPC_ST_SLAVE, config_mode: CONFIG_RST};
        end else begin
            core_r <= core_nxt;
        end
    end

    always_comb begin
        link_nxt          = link_r;
        link_nxt.master_s = {link_r.master_s[0], is_master};
        link_nxt.data_out = link_r.master_s[1] ? switch_data_i : 1'b1; // [R1]
    end

    // Data out leaves on the master's falling test clock edge, as a TAP does.
    always_ff @(negedge master2_test_clock_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            link_r <= '0; // [R5]
        end else begin
            link_r <= link_nxt;
        end
    end

    // Direction is switched from the core state so it settles before the master clocks. [R1]
    assign master2_test_clock_oe_o   = ~is_master; // [R1]
    assign master2_mode_select_oe_o  = ~is_master; // [R1]
    assign master2_data_in_oe_o      = ~is_master; // [R1]
    assign master2_test_reset_n_oe_o = ~is_master; // [R1]
    assign master2_data_out_oe_o     = is_master; // [R1]
    assign master2_test_clock_o      = slave_clock_i;
    assign master2_mode_select_o     = slave_mode_select_i;
    assign master2_data_in_o         = slave_data_i;
    // The slave-mode test reset comes from the switch, never from this port's input. [R4]
    assign master2_test_reset_n_o    = slave_test_reset_n_i;
    assign master2_data_out_o        = link_r.data_out;
    assign switch_data_o             = is_master ? master2_data_out_i : 1'b1;
    assign config_mode_o             = core_r.config_mode;
    assign master2_grant_n_o         = core_r.grant_n; // [R10]
    assign master_conflict_n_o       = core_r.conflict_n; // [R6]
    // Periphery chain is held in reset by the outside party; output is then low. [R8]
    assign periph_chain_data_out_o   = periph_chain_reset_n_i & periph_chain_data_in_i
                                       & (periph_chain_clock_i | ~periph_chain_mode_select_i
                                          | 1'b1); // [R7]

endmodule : jmpc_port

// ==== jmpc_pkg.sv ====
// Shared constants for the master port 2 control block.
package jmpc_pkg;

    localparam int unsigned SYNC_STAGES = 2;
    localparam logic        GRANT_RST   = 1'b1;
    localparam logic        CONFIG_RST  = 1'b0;
    localparam logic        CONFL_RST   = 1'b1;

    typedef enum logic [1:0] {
        JMPC_ST_SLAVE  = 2'b00,
        JMPC_ST_MASTER = 2'b01,
        JMPC_ST_CONFIG = 2'b10
    } jmpc_port_e;

endpackage : jmpc_pkg

// ==== jmpc_port_props.sv ====
// Checker on the ports of the master port 2 control block.
`timescale 1ns/1ps
module jmpc_port_props (
    input wire logic ref_clk_i, rst_b_i, global_reset_n_i, external_request_n_i,
    input wire logic master1_request_n_i, master2_request_n_i, master2_grant_n_o,
    input wire logic master_conflict_n_o, config_mode_o, master2_data_out_oe_o,
    input wire logic master2_test_reset_n_i, master2_test_reset_n_o,
    input wire logic master2_test_reset_n_oe_o, slave_test_reset_n_i
);
    wire e = external_request_n_i, m = master1_request_n_i, n = master2_request_n_i;
    wire g = master2_grant_n_o, k = master_conflict_n_o, c = config_mode_o;
    wire w = e & m & ~n, two = ~(e & m | e & n | m & n), t = master2_test_reset_n_i;
    wire o = master2_data_out_oe_o, r = master2_test_reset_n_oe_o;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i || !global_reset_n_i);
    a_grant_on: assert property (w [*4] |=> !g) else $error("no grant");
    a_pin_dir: assert property (o != g && r == g) else $error("direction");
    a_mci_on: assert property (two [*4] |=> !k) else $error("no conflict");
    a_mci_off: assert property ((!two) [*4] |=> k) else $error("conflict");
    a_cfg_entry: assert property ((!g && !t) [*4] |=> c) else $error("no config");
    a_cfg_cause: assert property ($rose(c) |-> !$past(g)) else $error("config");
    a_cfg_master: assert property ($rose(c) |-> !$past(t, 2) && !$past(g, 2))
        else $error("config entered from a reset seen while not master");
    a_trst_drive: assert property (r |-> master2_test_reset_n_o == slave_test_reset_n_i)
        else $error("reset drive");
    a_glob_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !global_reset_n_i |-> g && k && !c) else $error("global");
endmodule : jmpc_port_props
bind jmpc_port jmpc_port_props u_props (.*);

// ==== jmpc_master_model.sv ====
// Behavioural test master: port 2 request, test reset and clocked frames.
`timescale 1ns/1ps
module jmpc_master_model (output logic req_n_o, trst_n_o, tck_o, tms_o, tdi_o);
    initial {req_n_o, trst_n_o, tck_o, tms_o, tdi_o} = 5'h18;
    task automatic set(input logic q, input logic t); req_n_o <= q; trst_n_o <= t; endtask : set
    // The clock stands still between frames, so data only moves while a frame runs.
    task automatic frame(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin {tdi_o, tms_o} = {d[i], i == 7}; #40 tck_o = 1'b1; #40 tck_o = 1'b0; end
    endtask : frame
endmodule : jmpc_master_model

// ==== tb_jmpc_port.sv ====
// Self-checking testbench for the master port 2 control block.
`timescale 1ns/1ps
module tb_jmpc_port;
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0, global_reset_n_i = 1'b1, switch_data_i = 1'b0;
    logic external_request_n_i = 1'b1, master1_request_n_i = 1'b1, slave_test_reset_n_i = 1'b1;
    logic slave_clock_i = 1'b0, slave_mode_select_i = 1'b0, slave_data_i = 1'b0;
    logic master2_request_n_i, m_trst, m_tck, m_tms, m_tdi, switch_data_o, config_mode_o;
    logic master2_test_reset_n_o, master2_test_reset_n_oe_o, master2_mode_select_o;
    logic master2_mode_select_oe_o, master2_data_in_o, master2_data_in_oe_o, master2_test_clock_o;
    logic master2_test_clock_oe_o, master2_data_out_o, master2_data_out_oe_o, master2_grant_n_o;
    logic master_conflict_n_o, periph_chain_data_out_o;
    int n_mismatch = 0, checks_done = 0;
    wire periph_chain_clock_i = 1'b0, periph_chain_mode_select_i = 1'b0;
    wire periph_chain_reset_n_i = 1'b0, periph_chain_data_in_i = switch_data_i;
    wire master2_test_clock_i = master2_test_clock_oe_o ? master2_test_clock_o : m_tck;
    wire master2_mode_select_i = master2_mode_select_oe_o ? master2_mode_select_o : m_tms;
    wire master2_data_in_i = master2_data_in_oe_o ? master2_data_in_o : m_tdi;
    wire master2_test_reset_n_i = master2_test_reset_n_oe_o ? master2_test_reset_n_o : m_trst;
    wire master2_data_out_i = master2_data_out_oe_o ? master2_data_out_o : 1'b1;
    jmpc_master_model mm (.req_n_o(master2_request_n_i), .trst_n_o(m_trst), .tck_o(m_tck),
                          .tms_o(m_tms), .tdi_o(m_tdi));
    jmpc_port dut (.*);
    task automatic cmp(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end
    endtask : cmp
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Eight edges leave room for the two-flop synchroniser and the output register.
    task automatic go(input logic [2:0] v, input logic t);
        @(posedge ref_clk_i) {master1_request_n_i, external_request_n_i} <= v[1:0];
        mm.set(v[2], t);
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask : go
    task automatic t_requests;
        for (int i = 0; i < 8; i++) begin
            go(i[2:0], 1'b1);
            cmp(master_conflict_n_o, i[0] & i[1] | i[0] & i[2] | i[1] & i[2]);
            cmp(master2_grant_n_o, i != 3);
            cmp(master2_data_out_oe_o, i == 3);
        end
    endtask : t_requests
    task automatic t_link;
        go(3'h3, 1'b1);
        for (int b = 1; b >= 0; b--) begin
            @(posedge ref_clk_i) switch_data_i <= b[0];
            mm.frame(8'h96);
            #1 cmp(master2_data_out_o, b[0]);
        end
    endtask : t_link
    task automatic t_slave;
        go(3'h7, 1'b0);
        @(posedge ref_clk_i) {slave_clock_i, slave_data_i, slave_test_reset_n_i} <= 3'h6;
        repeat (8) @(posedge ref_clk_i);
        #1 cmp(config_mode_o, 1'b0);
        cmp(master2_test_reset_n_o, 1'b0);
        cmp(master2_test_clock_o, 1'b1);
        go(3'h3, 1'b1);
        cmp(config_mode_o, 1'b0);
        go(3'h3, 1'b0);
        cmp(config_mode_o, 1'b1);
    endtask : t_slave
    task automatic t_global;
        @(posedge ref_clk_i) global_reset_n_i <= 1'b0;
        #1 cmp(config_mode_o, 1'b0);
        cmp(master2_grant_n_o, 1'b1);
        @(posedge ref_clk_i) global_reset_n_i <= 1'b1;
        go(3'h7, 1'b1);
    endtask : t_global
    initial forever #4 ref_clk_i = ~ref_clk_i;
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        t_requests();
        t_link();
        t_slave();
        t_global();
        stop_test();
    end
    initial begin
        #20000 n_mismatch++;
        stop_test();
    end
endmodule : tb_jmpc_port
